// >>> rtl/rwsc_top.v
// reset, wake indicator and strap control of the ethernet controller
// Function
// - reset pin resets every register, the speed strap registers to high
// - open pin pulled up, power-on reset used
// - writes ignored until a host read
// - enabled wake event asserts wake indicator
// - wake indicator polarity and drive selectable
// - only host write wakes the device
// - any write data wakes the device
// - crossover enable follows strap, low default
// - speed strap latched at reset release
// - speed strap picks default speed and autonegotiation, duplex fixed half
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
`include "rwsc_defines.vh"
module rwsc_top (
  input wire clock, // 100 mhz clock
  input wire nrst, // power-on reset, low
  input wire external_reset_low, // reset pin, low
  input wire host_select_low, // host chip select, low
  input wire host_write_strobe_low, // host write strobe, low
  input wire wake_event, // wake event pulse from detectors
  input wire crossover_auto_enable_strap, // crossover strap, high enables
  input wire speed_strap, // default speed strap, high 100
  input wire [7:0] addr, // register address
  input wire [31:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [31:0] rdata, // read data one cycle after rd
  output reg wake_indicator_out, // wake indicator pin level
  output reg wake_indicator_oe, // wake indicator output enable
  output reg crossover_auto_enable, // crossover detection enabled
  output reg link_speed_100, // default speed 100
  output reg link_full_duplex, // default duplex
  output reg link_autoneg_en, // default autonegotiation
  output reg sleeping, // in power-saving state
  output reg irq // interrupt, high
);
  // ----------------------------------------
  // reset
  // ----------------------------------------
  wire rst_low;
  wire xover_sync;
  wire speed_sync;
  wire host_wr_sync;
  rwsc_reset_merge u_reset (
    .clock(clock),
    .por_low(nrst),
    .external_reset_low(external_reset_low),
    .rst_low(rst_low)
  );
  rwsc_sync2 #(
    .RST_VAL(1'b0) // undriven crossover strap reads low
  ) u_xover (
    .clock(clock),
    .nrst(rst_low),
    .d(crossover_auto_enable_strap),
    .q(xover_sync)
  );
  rwsc_sync2 #(
    .RST_VAL(1'b1) // undriven speed strap reads high
  ) u_speed (
    .clock(clock),
    .nrst(rst_low),
    .d(speed_strap),
    .q(speed_sync)
  );
  rwsc_sync2 #(
    .RST_VAL(1'b0) // idle host pins give no write
  ) u_hwr (
    .clock(clock),
    .nrst(rst_low),
    .d(~(host_select_low | host_write_strobe_low)),
    .q(host_wr_sync)
  );
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [4:0] ctrl_reg;
  reg [2:0] mask_reg;
  reg [2:0] stat_reg;
  reg permit_reg;
  reg sleep_reg;
  reg wake_reg;
  reg [1:0] strap_cnt_reg;
  reg speed_reg;
  reg hwr_d_reg;
  reg [2:0] stat_next;
  reg [31:0] status_word;
  reg sel_ctrl;
  reg sel_status;
  reg sel_irq_stat;
  reg sel_irq_mask;
  reg sel_byte_test;
  wire host_wr_rise;
  wire wr_ok;
  wire go_sleep;
  wire rd_stat;
  wire ev_wake;
  wire ev_woke;
  wire ev_drop;
  wire wr_ctrl;
  wire wr_mask;
  wire wake_clr;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always @* begin
    sel_ctrl = 1'b0;
    sel_status = 1'b0;
    sel_irq_stat = 1'b0;
    sel_irq_mask = 1'b0;
    sel_byte_test = 1'b0;
    if (addr == `RWSC_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (addr == `RWSC_OFF_STATUS) begin
      sel_status = 1'b1;
    end else if (addr == `RWSC_OFF_IRQ_STAT) begin
      sel_irq_stat = 1'b1;
    end else if (addr == `RWSC_OFF_IRQ_MASK) begin
      sel_irq_mask = 1'b1;
    end else if (addr == `RWSC_OFF_BYTE_TEST) begin
      sel_byte_test = 1'b1;
    end
  end
  // ----------------------------------------
  // events
  // ----------------------------------------
  assign host_wr_rise = host_wr_sync & ~hwr_d_reg;
  assign wr_ok = wr & permit_reg;
  assign wr_ctrl = wr_ok & sel_ctrl;
  assign wr_mask = wr_ok & sel_irq_mask;
  assign go_sleep = wr_ctrl & wdata[`RWSC_CTRL_SLEEP];
  assign wake_clr = wr_ctrl & wdata[`RWSC_CTRL_WAKE_CLR];
  assign rd_stat = rd & sel_irq_stat;
  assign ev_wake = wake_event & ctrl_reg[`RWSC_CTRL_WAKE_EN];
  // a host write cycle on the pins is the only way out of sleep
  assign ev_woke = host_wr_rise & sleep_reg;
  // a refused write is flagged even while asleep
  assign ev_drop = wr & ~permit_reg;
  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // the synchronisers restart with the reset, so the capture waits until
  // the strap level has passed both stages
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != `RWSC_STRAP_DONE) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      speed_reg <= `RWSC_SPEED_RST;
    end else if (strap_cnt_reg == `RWSC_STRAP_WAIT) begin
      speed_reg <= speed_sync;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      link_speed_100 <= 1'b0;
      link_autoneg_en <= 1'b0;
      link_full_duplex <= 1'b0;
      crossover_auto_enable <= 1'b0;
    end else begin
      link_speed_100 <= speed_reg;
      link_autoneg_en <= speed_reg;
      link_full_duplex <= 1'b0;
      crossover_auto_enable <= xover_sync;
    end
  end
  // ----------------------------------------
  // write permit and sleep
  // ----------------------------------------
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      hwr_d_reg <= 1'b0;
    end else begin
      hwr_d_reg <= host_wr_sync;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      sleep_reg <= 1'b0;
    end else if (go_sleep) begin
      sleep_reg <= 1'b1;
    end else if (ev_woke) begin
      sleep_reg <= 1'b0;
    end
  end
  // sleep entry drops the permit, reads while asleep do not restore it
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      permit_reg <= 1'b0;
    end else if (go_sleep) begin
      permit_reg <= 1'b0;
    end else if (rd && !sleep_reg) begin
      permit_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      ctrl_reg <= `RWSC_CTRL_RST;
    end else if (wr_ctrl) begin
      // sleep and clear are strobes and read back as zero
      ctrl_reg <= {2'h0, wdata[`RWSC_CTRL_WAKE_OD:`RWSC_CTRL_WAKE_EN]};
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      mask_reg <= `RWSC_MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= wdata[2:0];
    end
  end
  // ----------------------------------------
  // wake indicator
  // ----------------------------------------
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      wake_reg <= 1'b0;
    end else if (ev_wake) begin
      wake_reg <= 1'b1;
    end else if (wake_clr || !ctrl_reg[`RWSC_CTRL_WAKE_EN]) begin
      wake_reg <= 1'b0;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      wake_indicator_out <= 1'b0;
      wake_indicator_oe <= 1'b0;
    end else if (ctrl_reg[`RWSC_CTRL_WAKE_OD]) begin
      // open drain: drive only the active-low level
      wake_indicator_out <= 1'b0;
      wake_indicator_oe <= wake_reg;
    end else begin
      wake_indicator_out <= wake_reg ~^ ctrl_reg[`RWSC_CTRL_WAKE_POL];
      wake_indicator_oe <= 1'b1;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= sleep_reg;
    end
  end
  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always @* begin
    // a read clears the status, an event in the same cycle still sets it
    stat_next = rd_stat ? 3'h0 : stat_reg;
    if (ev_wake) begin
      stat_next[`RWSC_IRQ_WAKE] = 1'b1;
    end
    if (ev_woke) begin
      stat_next[`RWSC_IRQ_WOKE] = 1'b1;
    end
    if (ev_drop) begin
      stat_next[`RWSC_IRQ_DROP] = 1'b1;
    end
  end
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq <= |(stat_next & mask_reg);
    end
  end
  // ----------------------------------------
  // status word
  // ----------------------------------------
  always @* begin
    status_word = 32'h0;
    status_word[`RWSC_ST_SPEED] = speed_reg;
    status_word[`RWSC_ST_AUTONEG] = speed_reg;
    status_word[`RWSC_ST_DUPLEX] = 1'b0;
    status_word[`RWSC_ST_XOVER] = crossover_auto_enable;
    status_word[`RWSC_ST_SLEEP] = sleep_reg;
    status_word[`RWSC_ST_PERMIT] = permit_reg;
    status_word[`RWSC_ST_WAKE] = wake_reg;
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge clock or negedge rst_low) begin
    if (!rst_low) begin
      rdata <= 32'h0;
    end else if (!rd) begin
      rdata <= 32'h0;
    end else if (sel_ctrl) begin
      rdata <= {27'h0, ctrl_reg};
    end else if (sel_status) begin
      rdata <= status_word;
    end else if (sel_irq_stat) begin
      rdata <= {29'h0, stat_reg};
    end else if (sel_irq_mask) begin
      rdata <= {29'h0, mask_reg};
    end else if (sel_byte_test) begin
      rdata <= `RWSC_BYTE_TEST_VAL;
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule

// >>> rtl/rwsc_defines.vh
// constants of the reset, wake and strap control block
`ifndef RWSC_DEFINES_VH
`define RWSC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RWSC_OFF_CTRL 8'h00
`define RWSC_OFF_STATUS 8'h04
`define RWSC_OFF_IRQ_STAT 8'h08
`define RWSC_OFF_IRQ_MASK 8'h0c
`define RWSC_OFF_BYTE_TEST 8'h10
// ----------------------------------------
// control fields
// ----------------------------------------
`define RWSC_CTRL_WAKE_EN 0
`define RWSC_CTRL_WAKE_POL 1
`define RWSC_CTRL_WAKE_OD 2
`define RWSC_CTRL_SLEEP 3
`define RWSC_CTRL_WAKE_CLR 4
// ----------------------------------------
// status fields and reset values
// ----------------------------------------
`define RWSC_ST_SPEED 0
`define RWSC_ST_AUTONEG 1
`define RWSC_ST_DUPLEX 2
`define RWSC_ST_XOVER 3
`define RWSC_ST_SLEEP 4
`define RWSC_ST_PERMIT 5
`define RWSC_ST_WAKE 6
`define RWSC_IRQ_WAKE 0
`define RWSC_IRQ_WOKE 1
`define RWSC_IRQ_DROP 2
`define RWSC_CTRL_RST 5'h00
`define RWSC_MASK_RST 3'h0
`define RWSC_SPEED_RST 1'b1
// ----------------------------------------
// timing counts and byte test value
// ----------------------------------------
`define RWSC_STRAP_WAIT 2'h2
`define RWSC_STRAP_DONE 2'h3
`define RWSC_BYTE_TEST_VAL 32'h87654321
`endif

// >>> rtl/rwsc_sync2.v
// two-flop synchroniser for one level
`timescale 1ns/1ns
module rwsc_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire clock, // clock
  input wire nrst, // async reset, low
  input wire d, // level in
  output reg q // synchronised level
);
  reg meta_reg;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// >>> rtl/rwsc_reset_merge.v
// merge of the external reset pin with the power-on reset
`timescale 1ns/1ns
module rwsc_reset_merge (
  input wire clock, // clock
  input wire por_low, // internal power-on reset, low
  input wire external_reset_low, // reset pin, pulled up when open
  output reg rst_low // merged reset, async assert, sync release
);
  reg stage_reg;
  wire any_low;
  // an open pin reads high, so only the power-on reset then acts
  assign any_low = por_low & external_reset_low;
  always @(posedge clock or negedge any_low) begin
    if (!any_low) begin
      stage_reg <= 1'b0;
      rst_low <= 1'b0;
    end else begin
      stage_reg <= 1'b1;
      rst_low <= stage_reg;
    end
  end
endmodule

// >>> tb/rwsc_top_asserts.sv
// port assertions of the reset, wake and strap block
`timescale 1ns/1ns
module rwsc_top_asserts (
  input wire clock, // clock
  input wire nrst, // power-on reset, low
  input wire external_reset_low, // reset pin, low
  input wire host_select_low, // chip select, low
  input wire host_write_strobe_low, // write strobe, low
  input wire crossover_auto_enable_strap, // crossover strap
  input wire rd, // read strobe
  input wire [31:0] rdata, // read data
  input wire wake_indicator_oe, // wake pin enable
  input wire crossover_auto_enable, // crossover enabled
  input wire link_speed_100, // default speed
  input wire link_full_duplex, // default duplex
  input wire link_autoneg_en, // default autonegotiation
  input wire sleeping, // power-saving state
  input wire irq // interrupt
);
  wire rn = nrst & external_reset_low;
  reg [2:0] up_reg;
  // cycles since reset release, saturating
  always @(posedge clock or negedge rn) begin
    if (!rn) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rn);
  property p_rst; disable iff (1'b0) !rn |-> !sleeping && !irq && !wake_indicator_oe; endproperty
  a_rst: assert property (p_rst) else $error("outputs set in reset");
  property p_dup; !link_full_duplex; endproperty
  a_dup: assert property (p_dup) else $error("full duplex");
  property p_aneg; up_reg == 3'h7 |-> link_autoneg_en == link_speed_100; endproperty
  a_aneg: assert property (p_aneg) else $error("autoneg differs");
  property p_latch; up_reg == 3'h7 |-> $stable(link_speed_100); endproperty
  a_latch: assert property (p_latch) else $error("speed moved");
  property p_xov;
    up_reg == 3'h7 |-> crossover_auto_enable == $past(crossover_auto_enable_strap, 3);
  endproperty
  a_xov: assert property (p_xov) else $error("crossover wrong");
  property p_wake;
    $rose(!host_select_low && !host_write_strobe_low) && sleeping |-> ##[1:4] !sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_stay; (sleeping && host_select_low)[*4] |=> sleeping; endproperty
  a_stay: assert property (p_stay) else $error("woke alone");
  property p_rd; !rd |=> rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
endmodule
bind rwsc_top rwsc_top_asserts chk (.clock, .nrst, .external_reset_low, .host_select_low,
  .host_write_strobe_low, .crossover_auto_enable_strap, .rd, .rdata, .wake_indicator_oe,
  .crossover_auto_enable, .link_speed_100, .link_full_duplex, .link_autoneg_en, .sleeping, .irq);

// >>> tb/rwsc_host_model.sv
// host model pulsing chip select and write strobe for a wake-up write
`timescale 1ns/1ns
module rwsc_host_model (
  input wire clock, // clock
  input wire go, // request one wake-up write
  output wire host_select_low, // chip select, low
  output wire host_write_strobe_low // write strobe, low
);
  reg [1:0] cnt_reg = 2'h0;
  always @(posedge clock) begin
    if (go) cnt_reg <= 2'h2;
    else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
  end
  assign host_select_low = cnt_reg == 2'h0;
  assign host_write_strobe_low = cnt_reg == 2'h0;
endmodule

// >>> tb/rwsc_top_tb.sv
// testbench of the reset, wake and strap block
`timescale 1ns/1ns
`include "rwsc_defines.vh"
module rwsc_top_tb;
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg ext_low = 1'b1;
  reg wev = 1'b0;
  reg xs = 1'b0;
  reg ss = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg go = 1'b0;
  reg [31:0] d;
  wire csl, wel, w_out, w_oe, x_en, spd, fdx, aneg, sleeping, irq;
  wire [31:0] rdata;
  integer errors = 0;
  integer n_compared = 0;
  integer i;
  rwsc_host_model host (.clock(clock), .go(go), .host_select_low(csl),
    .host_write_strobe_low(wel));
  rwsc_top DUT (.clock(clock), .nrst(nrst), .external_reset_low(ext_low),
    .host_select_low(csl), .host_write_strobe_low(wel), .wake_event(wev),
    .crossover_auto_enable_strap(xs), .speed_strap(ss), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wake_indicator_out(w_out), .wake_indicator_oe(w_oe),
    .crossover_auto_enable(x_en), .link_speed_100(spd), .link_full_duplex(fdx),
    .link_autoneg_en(aneg), .sleeping(sleeping), .irq(irq));
  task summarize;
    begin
      if (errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [127:0] what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task wr_reg(input [7:0] a, input [31:0] v);
    begin
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task pulse;
    begin
      @(posedge clock);
      wev <= 1'b1;
      @(posedge clock);
      wev <= 1'b0;
      cyc(4);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_strap(input s);
    begin
      @(posedge clock);
      ext_low <= 1'b0;
      ss <= s;
      xs <= s;
      cyc(3);
      ext_low <= 1'b1;
      cyc(8);
      ss <= !s;
      xs <= !s;
      cyc(6);
      chk("link", {1'b0, s, s}, {fdx, aneg, spd});
      chk("xover", !s, x_en);
      wr_reg(`RWSC_OFF_CTRL, 32'h1);
      rd_reg(`RWSC_OFF_IRQ_STAT);
      chk("drop", 32'h4, d);
      rd_reg(`RWSC_OFF_CTRL);
      chk("ctrl", `RWSC_CTRL_RST, d);
      rd_reg(`RWSC_OFF_STATUS);
      chk("status", {!s, 1'b0, s, s} | 32'h20, d);
      rd_reg(8'h40);
      chk("unmapped", 32'h0, d);
      rd_reg(`RWSC_OFF_BYTE_TEST);
      chk("byte", `RWSC_BYTE_TEST_VAL, d);
    end
  endtask
  task t_wake;
    begin
      wr_reg(`RWSC_OFF_IRQ_MASK, 32'h1);
      wr_reg(`RWSC_OFF_CTRL, 32'h3);
      pulse;
      chk("pp", 2'h3, {w_oe, w_out});
      chk("irq", 1, irq);
      rd_reg(`RWSC_OFF_IRQ_STAT);
      chk("istat", 32'h1, d);
      cyc(2);
      chk("irq clr", 0, irq);
      wr_reg(`RWSC_OFF_IRQ_MASK, 32'h0);
      wr_reg(`RWSC_OFF_CTRL, 32'h15);
      pulse;
      chk("od", 2'h2, {w_oe, w_out});
      chk("irq mask", 0, irq);
      wr_reg(`RWSC_OFF_CTRL, 32'h11);
      cyc(2);
      chk("low idle", 2'h3, {w_oe, w_out});
      pulse;
      chk("low act", 2'h2, {w_oe, w_out});
    end
  endtask
  task t_sleep;
    begin
      wr_reg(`RWSC_OFF_CTRL, 32'h9);
      pulse;
      chk("asleep", 1, sleeping);
      rd_reg(`RWSC_OFF_STATUS);
      chk("sleep status", 32'h53, d);
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      i = 0;
      while (sleeping !== 1'b0 && i < 20) begin
        @(posedge clock);
        i = i + 1;
      end
      chk("woke", 1'b0, sleeping);
      if (i == 20) summarize;
      wr_reg(`RWSC_OFF_CTRL, 32'h0);
      rd_reg(`RWSC_OFF_CTRL);
      chk("ctrl kept", 32'h1, d);
      rd_reg(`RWSC_OFF_IRQ_STAT);
      chk("woke stat", 32'h7, d);
    end
  endtask
  task t_reset;
    begin
      @(posedge clock);
      ext_low <= 1'b0;
      cyc(3);
      chk("rst oe", 1'b0, w_oe);
      ext_low <= 1'b1;
      cyc(6);
      rd_reg(`RWSC_OFF_CTRL);
      chk("ctrl rst", `RWSC_CTRL_RST, d);
    end
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    cyc(12);
    nrst <= 1'b1;
    for (i = 0; i < 2; i = i + 1) t_strap(i[0]);
    t_wake;
    t_sleep;
    t_reset;
    summarize;
  end
endmodule
